// ### common/apd_pkg.sv
// Purpose: shared constants and carriers for the auto powerdown block
// Assumes: one 200 MHz clock, host strobes synchronous to it
// Notes: config bit positions are shared by direct and auto powerdown masks
package apd_pkg;

  // floppy register offsets on the host bus
  localparam logic [2:0] OFS_DRIVE_STATUS_A = 3'h0;
  localparam logic [2:0] OFS_DRIVE_STATUS_B = 3'h1;
  localparam logic [2:0] OFS_DRIVE_OUTPUT_CTRL = 3'h2;
  localparam logic [2:0] OFS_RATE_SELECT_MAIN = 3'h4;
  localparam logic [2:0] OFS_COMMAND_DATA = 3'h5;
  localparam logic [2:0] OFS_DISK_INPUT_RATE = 3'h7;

  // field positions
  localparam int MOTOR_BITS_LSB = 4;
  localparam int CTRL_RESET_N_BIT = 2;
  localparam int RATE_SOFT_RESET_BIT = 7;
  localparam int CFG_FDC_BIT = 0;
  localparam int CFG_PAR_BIT = 3;
  localparam int CFG_UART1_BIT = 4;
  localparam int CFG_UART2_BIT = 5;

  // values
  localparam logic [7:0] MAIN_STATE_IDLE = 8'h80;
  localparam logic [7:0] DRIVE_CTRL_RESET_VAL = 8'h00;
  localparam logic [7:0] RATE_SEL_RESET_VAL = 8'h02;
  localparam logic [7:0] RATE_CFG_RESET_VAL = 8'h00;
  localparam logic [7:0] RDATA_RESET_VAL = 8'h00;

  // extended control mode field encodings
  localparam logic [2:0] ECR_MODE_SPP = 3'h0;
  localparam logic [2:0] ECR_MODE_BIDIR = 3'h1;
  localparam logic [2:0] ECR_MODE_EPP = 3'h4;

  // powerdown timer: 10 ms at a 5 ns clock
  localparam int APD_TIME_MS = 10;
  localparam int CLK_PERIOD_NS = 5;
  localparam int APD_CYCLES = (APD_TIME_MS * 1000000) / CLK_PERIOD_NS;

  // one host bus cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } apd_host_t;

  // per serial port status from the uart core
  typedef struct packed {
    logic tx_hold_empty;
    logic tx_shift_empty;
    logic rx_fifo_empty;
    logic rx_idle;
    logic tx_buf_write;
    logic serial_rx_input;
    logic ring_indication_in;
  } apd_uart_t;

endpackage

// ### hw/apd_ctrl.sv
// Purpose: auto and direct powerdown control for floppy, two uarts, parallel
// Assumes: all inputs synchronous to CLK; cores supply their status levels
// Notes: every output is a field of the registered state
`timescale 1ns/1ps

module apd_ctrl
  import apd_pkg::*;
#(
  parameter int APD_COUNT = APD_CYCLES // shorten for simulation
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // configuration
  input wire logic [7:0] AUTO_POWERDOWN_CFG,
  input wire logic [7:0] DIRECT_POWERDOWN_CFG,
  // host bus
  input wire apd_host_t HOST,
  output logic [7:0] HOST_RDATA,
  // floppy core status
  input wire logic [7:0] FDC_STATUS_A,
  input wire logic [7:0] FDC_STATUS_B,
  input wire logic [7:0] FDC_MAIN_STATE,
  input wire logic [7:0] FDC_DATA_RD,
  input wire logic [7:0] FDC_DISK_INPUT,
  input wire logic FDC_INT,
  input wire logic FDC_DRQ,
  input wire logic FDC_HEAD_UNLOAD_DONE,
  input wire logic FDC_WRITE_DATA,
  input wire logic FDC_WRITE_GATE,
  input wire logic DMA_ACKNOWLEDGE_IN,
  input wire logic TERMINAL_COUNT_IN,
  // floppy core controls
  output logic FDC_POWERDOWN,
  output logic FDC_CLK_EN,
  output logic FDC_DATA_RD_STB,
  output logic FDC_DATA_WR_STB,
  output logic FDC_DMA_ACK,
  output logic FDC_TERMINAL_COUNT,
  output logic [7:0] FDC_RATE_SELECT,
  // host side request pins
  output logic INTERRUPT_REQUEST_OUT,
  output logic DMA_REQUEST_OUT,
  // drive pins
  output logic [3:0] MOTOR_ENABLE_OUT,
  output logic MOTOR_ENABLE_OE_N,
  output logic [3:0] DRIVE_SELECT_OUT,
  output logic DRIVE_SELECT_OE_N,
  output logic WRITE_DATA_OUT,
  output logic WRITE_GATE_OUT,
  output logic WRITE_OE_N,
  output logic [1:0] RATE_CODE_OUT,
  // serial ports
  input wire apd_uart_t [1:0] UART,
  output logic [1:0] UART_TX_POWERDOWN,
  output logic [1:0] UART_RX_POWERDOWN,
  output logic [1:0] RING_CHANGE,
  // parallel port
  input wire logic PAR_EPP_ENABLED,
  input wire logic PAR_ECP_ENABLED,
  input wire logic [2:0] ECR_MODE,
  output logic PAR_EPP_POWERDOWN,
  output logic PAR_ECP_POWERDOWN
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  // the whole state of the block
  typedef struct packed {
    logic [7:0] drv_ctrl; // drive output control as last written
    logic [7:0] rate_sel; // rate select as last written
    logic [7:0] rate_cfg; // rate config as last written
    logic [7:0] rdata;     // read data, one cycle after the strobe
    logic fdc_apd;         // floppy in auto powerdown
    logic fdc_pd;          // floppy in any powerdown
    logic [31:0] apd_cnt;  // powerdown timer
    logic clk_en;          // floppy core clock enable
    logic data_rd;         // data port read pulse to core
    logic data_wr;         // data port write pulse to core
    logic dack;            // forwarded acknowledge
    logic term_cnt; // forwarded terminal count
    logic irq;             // interrupt request pin
    logic drq;             // dma request pin
    logic [3:0] drv_sel; // decoded drive select
    logic wdat;            // write data pin
    logic wgate;           // write gate pin
    logic [1:0] tx_pd;     // transmitter asleep
    logic [1:0] rx_pd;     // receiver asleep
    logic [1:0] rx_prev;   // last receive level
    logic [1:0] ring_prev; // last ring level
    logic [1:0] ring_chg; // ring change pulse
    logic epp_pd;          // enhanced parallel logic asleep
    logic ecp_pd;          // extended parallel logic asleep
  } apd_state_t;

  apd_state_t s_q;
  apd_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // decoding

  // does this host cycle bring the floppy out of powerdown
  function automatic logic fdc_wakes(input apd_host_t h);
    logic w;
    w = 1'b0;
    if (h.rd && h.addr == OFS_RATE_SELECT_MAIN)
    begin
      w = 1'b1; // main state read
    end
    if ((h.rd || h.wr) && h.addr == OFS_COMMAND_DATA)
    begin
      w = 1'b1; // data port in either direction
    end
    if (h.wr && h.addr == OFS_DRIVE_OUTPUT_CTRL)
    begin
      // motor on or reset bit low
      w = (|h.wdata[MOTOR_BITS_LSB +: 4]) || !h.wdata[CTRL_RESET_N_BIT];
    end
    if (h.wr && h.addr == OFS_RATE_SELECT_MAIN)
    begin
      w = h.wdata[RATE_SOFT_RESET_BIT];
    end
    return w;
  endfunction

  // live read data; identical awake or asleep
  function automatic logic [7:0] read_mux(input logic [2:0] a, input logic [7:0] drv_ctrl);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      OFS_DRIVE_STATUS_A: r = FDC_STATUS_A;
      OFS_DRIVE_STATUS_B: r = FDC_STATUS_B;
      OFS_DRIVE_OUTPUT_CTRL: r = drv_ctrl;
      OFS_RATE_SELECT_MAIN: r = FDC_MAIN_STATE;
      OFS_COMMAND_DATA: r = FDC_DATA_RD;
      OFS_DISK_INPUT_RATE: r = FDC_DISK_INPUT;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic wake;        // this cycle wakes the floppy
  logic access;      // any floppy register access
  logic fdc_ready;   // all floppy sleep conditions true
  logic fdc_dpd;     // direct powerdown of the floppy
  logic par_en;      // parallel auto powerdown allowed

  // all next-state logic in one process
  always_comb
  begin
    s_d = s_q;
    wake = fdc_wakes(HOST);
    access = HOST.rd || HOST.wr;
    fdc_dpd = DIRECT_POWERDOWN_CFG[CFG_FDC_BIT];
    par_en = AUTO_POWERDOWN_CFG[CFG_PAR_BIT];

    // writes land in storage whether asleep or not
    if (HOST.wr && HOST.addr == OFS_DRIVE_OUTPUT_CTRL)
    begin
      s_d.drv_ctrl = HOST.wdata;
    end
    if (HOST.wr && HOST.addr == OFS_RATE_SELECT_MAIN)
    begin
      s_d.rate_sel = HOST.wdata;
    end
    if (HOST.wr && HOST.addr == OFS_DISK_INPUT_RATE)
    begin
      s_d.rate_cfg = HOST.wdata;
    end
    if (HOST.rd)
    begin
      s_d.rdata = read_mux(HOST.addr, s_q.drv_ctrl);
    end
    // data port strobes reach the core only on a real access
    s_d.data_rd = HOST.rd && HOST.addr == OFS_COMMAND_DATA;
    s_d.data_wr = HOST.wr && HOST.addr == OFS_COMMAND_DATA;

    // sleep conditions, using the value the drive control will hold
    fdc_ready = AUTO_POWERDOWN_CFG[CFG_FDC_BIT]
      && s_d.drv_ctrl[MOTOR_BITS_LSB +: 4] == 4'h0
      && FDC_MAIN_STATE == MAIN_STATE_IDLE && !FDC_INT
      && FDC_HEAD_UNLOAD_DONE;

    // timer: cleared when disabled or on wake, then counts up and holds
    if (!AUTO_POWERDOWN_CFG[CFG_FDC_BIT] || wake)
    begin
      s_d.apd_cnt = 32'h0000_0000;
    end
    else if (!s_q.fdc_apd && s_q.apd_cnt < 32'(APD_COUNT))
    begin
      s_d.apd_cnt = s_q.apd_cnt + 32'h0000_0001;
    end

    // auto powerdown state
    if (wake || !AUTO_POWERDOWN_CFG[CFG_FDC_BIT])
    begin
      s_d.fdc_apd = 1'b0;
    end
    else if (fdc_ready && s_q.apd_cnt >= 32'(APD_COUNT))
    begin
      s_d.fdc_apd = 1'b1;
    end
    // non-waking accesses leave fdc_apd alone
    s_d.fdc_pd = s_d.fdc_apd || fdc_dpd;

    // core clock runs while awake or for one cycle of a sleeping access,
    // then stops again by itself
    s_d.clk_en = !s_d.fdc_pd || access;

    // system pins: inputs keep working, request outputs held low asleep
    s_d.dack = DMA_ACKNOWLEDGE_IN;
    s_d.term_cnt = TERMINAL_COUNT_IN;
    s_d.irq = FDC_INT && !s_d.fdc_pd;
    s_d.drq = FDC_DRQ && !s_d.fdc_pd;

    // drive pins
    s_d.drv_sel = 4'h1 << s_d.drv_ctrl[1:0];
    s_d.wdat = FDC_WRITE_DATA;
    s_d.wgate = FDC_WRITE_GATE;

    // serial ports, one loop for both
    for (int i = 0; i < 2; i++)
    begin
      logic en;
      logic dpd;
      en = AUTO_POWERDOWN_CFG[CFG_UART1_BIT + i];
      dpd = DIRECT_POWERDOWN_CFG[CFG_UART1_BIT + i];
      s_d.rx_prev[i] = UART[i].serial_rx_input;
      s_d.ring_prev[i] = UART[i].ring_indication_in;
      // ring detection never sleeps
      s_d.ring_chg[i] = UART[i].ring_indication_in != s_q.ring_prev[i];
      // transmitter
      if (dpd)
      begin
        s_d.tx_pd[i] = 1'b1;
      end
      else if (!en || UART[i].tx_buf_write)
      begin
        s_d.tx_pd[i] = 1'b0;
      end
      else if (UART[i].tx_hold_empty && UART[i].tx_shift_empty)
      begin
        s_d.tx_pd[i] = 1'b1;
      end
      else
      begin
        s_d.tx_pd[i] = s_q.tx_pd[i]; // stays until a write
      end
      // receiver
      if (dpd)
      begin
        s_d.rx_pd[i] = 1'b1;
      end
      else if (!en || UART[i].serial_rx_input != s_q.rx_prev[i])
      begin
        s_d.rx_pd[i] = 1'b0;
      end
      else if (UART[i].rx_fifo_empty && UART[i].rx_idle && !s_q.rx_pd[i])
      begin
        s_d.rx_pd[i] = 1'b1;
      end
      else
      begin
        s_d.rx_pd[i] = s_q.rx_pd[i];
      end
    end

    // parallel port, recomputed every cycle from live mode inputs
    s_d.epp_pd = DIRECT_POWERDOWN_CFG[CFG_PAR_BIT] || (par_en && (!PAR_EPP_ENABLED
      || (PAR_ECP_ENABLED && ECR_MODE != ECR_MODE_EPP)));
    s_d.ecp_pd = DIRECT_POWERDOWN_CFG[CFG_PAR_BIT] || (par_en && (!PAR_ECP_ENABLED
      || ECR_MODE == ECR_MODE_SPP || ECR_MODE == ECR_MODE_BIDIR
      || ECR_MODE == ECR_MODE_EPP));
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // synchronous reset wakes everything
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      s_q <= '0;
      s_q.drv_ctrl <= DRIVE_CTRL_RESET_VAL;
      s_q.rate_sel <= RATE_SEL_RESET_VAL;
      s_q.rate_cfg <= RATE_CFG_RESET_VAL;
      s_q.rdata <= RDATA_RESET_VAL;
      s_q.clk_en <= 1'b1;
      s_q.drv_sel <= 4'h1;
      // edge detectors start at the pin level: an idle-high line gives no false wake
      s_q.rx_prev <= {UART[1].serial_rx_input, UART[0].serial_rx_input};
      s_q.ring_prev <= {UART[1].ring_indication_in, UART[0].ring_indication_in};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state

  assign HOST_RDATA = s_q.rdata;
  assign FDC_POWERDOWN = s_q.fdc_pd;
  assign FDC_CLK_EN = s_q.clk_en;
  assign FDC_DATA_RD_STB = s_q.data_rd;
  assign FDC_DATA_WR_STB = s_q.data_wr;
  assign FDC_DMA_ACK = s_q.dack;
  assign FDC_TERMINAL_COUNT = s_q.term_cnt;
  assign FDC_RATE_SELECT = s_q.rate_sel;
  assign INTERRUPT_REQUEST_OUT = s_q.irq;
  assign DMA_REQUEST_OUT = s_q.drq;
  assign MOTOR_ENABLE_OUT = s_q.drv_ctrl[MOTOR_BITS_LSB +: 4];
  // tristate in powerdown; the rate code pins stay driven
  assign MOTOR_ENABLE_OE_N = s_q.fdc_pd;
  assign DRIVE_SELECT_OUT = s_q.drv_sel;
  assign DRIVE_SELECT_OE_N = s_q.fdc_pd;
  assign WRITE_DATA_OUT = s_q.wdat;
  assign WRITE_GATE_OUT = s_q.wgate;
  assign WRITE_OE_N = s_q.fdc_pd;
  assign RATE_CODE_OUT = s_q.rate_cfg[1:0];
  assign UART_TX_POWERDOWN = s_q.tx_pd;
  assign UART_RX_POWERDOWN = s_q.rx_pd;
  assign RING_CHANGE = s_q.ring_chg;
  assign PAR_EPP_POWERDOWN = s_q.epp_pd;
  assign PAR_ECP_POWERDOWN = s_q.ecp_pd;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_main_read_wakes: assert property (@(posedge CLK) disable iff (!RESET_N)
    HOST.rd && HOST.addr == OFS_RATE_SELECT_MAIN && !fdc_dpd |=> !FDC_POWERDOWN)
    else $error("main state read did not wake floppy");

  a_status_keeps_sleep: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_q.fdc_apd && HOST.rd && HOST.addr == OFS_DRIVE_STATUS_A
      && AUTO_POWERDOWN_CFG[CFG_FDC_BIT] |=> s_q.fdc_apd)
    else $error("status read woke floppy");

  a_motor_write_wakes: assert property (@(posedge CLK) disable iff (!RESET_N)
    HOST.wr && HOST.addr == OFS_DRIVE_OUTPUT_CTRL && |HOST.wdata[7:4] |=> !s_q.fdc_apd)
    else $error("motor write did not wake floppy");

  a_write_kept: assert property (@(posedge CLK) disable iff (!RESET_N)
    HOST.wr && HOST.addr == OFS_DISK_INPUT_RATE |=> RATE_CODE_OUT == $past(HOST.wdata[1:0]))
    else $error("rate write lost");

  a_sleep_read_live: assert property (@(posedge CLK) disable iff (!RESET_N)
    HOST.rd && HOST.addr == OFS_DRIVE_STATUS_B |=> HOST_RDATA == $past(FDC_STATUS_B))
    else $error("sleeping read not live");

  a_clock_regates: assert property (@(posedge CLK) disable iff (!RESET_N)
    FDC_POWERDOWN && !HOST.rd && !HOST.wr ##1 FDC_POWERDOWN && !HOST.rd && !HOST.wr
      |-> !FDC_CLK_EN)
    else $error("core clock left running");

  a_irq_held_low: assert property (@(posedge CLK) disable iff (!RESET_N)
    FDC_POWERDOWN |-> !INTERRUPT_REQUEST_OUT && !DMA_REQUEST_OUT)
    else $error("request pin active asleep");

  a_pins_tristate: assert property (@(posedge CLK) disable iff (!RESET_N)
    FDC_POWERDOWN == MOTOR_ENABLE_OE_N && FDC_POWERDOWN == WRITE_OE_N)
    else $error("drive pins not tristated");

  a_timer_before_pd: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(s_q.fdc_apd) |-> $past(s_q.apd_cnt) >= 32'(APD_COUNT))
    else $error("floppy slept before timer");

  a_tx_write_wakes: assert property (@(posedge CLK) disable iff (!RESET_N)
    UART[0].tx_buf_write && !DIRECT_POWERDOWN_CFG[CFG_UART1_BIT] |=> !UART_TX_POWERDOWN[0])
    else $error("transmit write did not wake");

  a_rx_edge_wakes: assert property (@(posedge CLK) disable iff (!RESET_N)
    $changed(UART[1].serial_rx_input) && !DIRECT_POWERDOWN_CFG[CFG_UART2_BIT]
      |=> !UART_RX_POWERDOWN[1])
    else $error("receive edge did not wake");

  a_uart_needs_en: assert property (@(posedge CLK) disable iff (!RESET_N)
    !AUTO_POWERDOWN_CFG[CFG_UART1_BIT] && !DIRECT_POWERDOWN_CFG[CFG_UART1_BIT]
      |=> !UART_TX_POWERDOWN[0] && !UART_RX_POWERDOWN[0])
    else $error("uart slept without enable");

  a_par_needs_en: assert property (@(posedge CLK) disable iff (!RESET_N)
    !AUTO_POWERDOWN_CFG[CFG_PAR_BIT] && !DIRECT_POWERDOWN_CFG[CFG_PAR_BIT]
      |=> !PAR_EPP_POWERDOWN && !PAR_ECP_POWERDOWN)
    else $error("parallel slept without enable");

  a_ring_reported: assert property (@(posedge CLK) disable iff (!RESET_N)
    ##1 $changed(UART[0].ring_indication_in) |=> RING_CHANGE[0])
    else $error("ring change missed");

endmodule // apd_ctrl

// ### test/apd_host_model.sv
// Purpose: host processor model for the floppy register bus
// Assumes: strobes change on the falling clock edge, one request per call
// Notes: read data is taken half a cycle after the read strobe was sampled, on the next falling edge
`timescale 1ns/1ps

module apd_host_model
  import apd_pkg::*;
(
  // clock
  input wire logic clk,
  // bus toward the block
  output apd_host_t host,
  input wire logic [7:0] rdata
);
  // bus starts idle
  initial host = '0;

  //////////////////////////////////////////////////////////////
  // one write; the strobe is seen by exactly one rising edge
  task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    host = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    host.wr = 1'b0;
    host.wdata = ~d; // released data must not keep showing the old byte
  endtask

  // one read; data registered at the strobe edge, taken half a cycle later
  task automatic bus_read(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    host = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    host.rd = 1'b0;
    d = rdata;
  endtask
endmodule // apd_host_model

// ### test/testbench.sv
// Purpose: self-checking bench for the peripheral auto powerdown block
// Assumes: timer shortened to N cycles; host bus driven by the partner model
// Notes: all inputs change on the falling edge, outputs sampled there too
`timescale 1ns/1ps

module testbench
  import apd_pkg::*;
  ;
  localparam int N = 20; // short powerdown timer keeps the run brief

  // clock, reset, configuration
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] auto_cfg = 8'h00;
  logic [7:0] direct_cfg = 8'h00;
  // floppy core side
  logic [7:0] live = 8'h3c; // live status, changed while asleep
  logic [7:0] ms = MAIN_STATE_IDLE;
  logic fint = 1'b0;
  logic fdrq = 1'b0;
  logic hud = 1'b1;
  logic dack = 1'b0;
  logic tcin = 1'b0;
  logic fwd = 1'b0;
  logic fgate = 1'b0;
  // serial and parallel side
  apd_uart_t [1:0] uart = '0;
  logic pepp = 1'b0;
  logic pecp = 1'b0;
  logic [2:0] ecr = ECR_MODE_SPP;
  // host bus and observed outputs
  apd_host_t host;
  logic [7:0] rdata, rsel, d;
  logic fpd, clken, irq, drq, dmaack, tco, mot_oe_n, dsel_oe_n, wr_oe_n, epd, cpd;
  logic rdstb, wrstb, wdo, wgo;
  logic [3:0] dsel, mot;
  logic [1:0] rate, txpd, rxpd, ring;
  int errors = 0;
  int checked = 0;

  always #2.5 clk = ~clk;

  apd_host_model host_m (.clk(clk), .host(host), .rdata(rdata));

  apd_ctrl #(.APD_COUNT(N)) dut (
    .CLK(clk), .RESET_N(rst_n), .AUTO_POWERDOWN_CFG(auto_cfg),
    .DIRECT_POWERDOWN_CFG(direct_cfg), .HOST(host), .HOST_RDATA(rdata),
    .FDC_STATUS_A(live), .FDC_STATUS_B(live ^ 8'h5a), .FDC_MAIN_STATE(ms),
    .FDC_DATA_RD(live ^ 8'h33), .FDC_DISK_INPUT(live ^ 8'hc3), .FDC_INT(fint),
    .FDC_DRQ(fdrq), .FDC_HEAD_UNLOAD_DONE(hud), .FDC_WRITE_DATA(fwd),
    .FDC_WRITE_GATE(fgate), .DMA_ACKNOWLEDGE_IN(dack), .TERMINAL_COUNT_IN(tcin),
    .FDC_POWERDOWN(fpd), .FDC_CLK_EN(clken), .FDC_DATA_RD_STB(rdstb),
    .FDC_DATA_WR_STB(wrstb), .FDC_DMA_ACK(dmaack), .FDC_TERMINAL_COUNT(tco),
    .FDC_RATE_SELECT(rsel), .INTERRUPT_REQUEST_OUT(irq), .DMA_REQUEST_OUT(drq),
    .MOTOR_ENABLE_OUT(mot), .MOTOR_ENABLE_OE_N(mot_oe_n), .DRIVE_SELECT_OUT(dsel),
    .DRIVE_SELECT_OE_N(dsel_oe_n), .WRITE_DATA_OUT(wdo), .WRITE_GATE_OUT(wgo),
    .WRITE_OE_N(wr_oe_n), .RATE_CODE_OUT(rate),
    .UART(uart), .UART_TX_POWERDOWN(txpd), .UART_RX_POWERDOWN(rxpd), .RING_CHANGE(ring),
    .PAR_EPP_ENABLED(pepp), .PAR_ECP_ENABLED(pecp), .ECR_MODE(ecr),
    .PAR_EPP_POWERDOWN(epd), .PAR_ECP_POWERDOWN(cpd)
  );

  //////////////////////////////////////////////////////////////
  // compare, count, report at once
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run, shared with the watchdog
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // wait for floppy sleep; lo bounds how early it may come after a wake
  task automatic await_sleep(input int lo);
    int n;
    n = 0;
    while (fpd !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check(8'(n >= lo && n <= N + 3), 8'h01);
  endtask

  //////////////////////////////////////////////////////////////
  // enter sleep; pins tristate, requests held low, bus inputs live
  task automatic test_sleep();
    check({3'h0, fpd, dsel}, 8'h01);
    check(rsel, RATE_SEL_RESET_VAL);
    auto_cfg[CFG_FDC_BIT] = 1'b1;
    await_sleep(N - 3);
    check({mot_oe_n, dsel_oe_n, wr_oe_n}, 8'h07);
    fdrq = 1'b1;
    dack = 1'b1;
    tcin = 1'b1;
    settle(2);
    check({irq, drq}, 8'h00);
    check({dmaack, tco}, 8'h03);
    fdrq = 1'b0;
    dack = 1'b0;
    tcin = 1'b0;
    $display("test sleep done");
  endtask

  // quiet accesses: true status, stored writes, back to low power
  task automatic test_quiet();
    live = 8'ha5;
    host_m.bus_read(OFS_DRIVE_STATUS_A, d);
    check(d, 8'ha5);
    host_m.bus_read(OFS_DRIVE_STATUS_B, d);
    check(d, 8'hff);
    host_m.bus_read(OFS_DISK_INPUT_RATE, d);
    check(d, 8'h66);
    host_m.bus_write(OFS_DRIVE_OUTPUT_CTRL, 8'h05);
    host_m.bus_write(OFS_RATE_SELECT_MAIN, 8'h03);
    host_m.bus_write(OFS_DISK_INPUT_RATE, 8'h02);
    host_m.bus_read(OFS_DRIVE_OUTPUT_CTRL, d);
    check(d, 8'h05);
    check(fpd, 8'h01);
    settle(2);
    check({fpd, clken}, 8'h02);
    check(rsel, 8'h03);
    check(rate, 8'h02);
    host_m.bus_read(OFS_RATE_SELECT_MAIN, d);
    check(d, MAIN_STATE_IDLE);
    check({fpd, dsel_oe_n, dsel}, 8'h02);
    await_sleep(N - 3);
    $display("test quiet done");
  endtask

  // every waking access, each followed by a fresh sleep
  task automatic test_wakes();
    logic [2:0] wa [6];
    logic [7:0] wv [6];
    wa = '{OFS_RATE_SELECT_MAIN, OFS_COMMAND_DATA, OFS_COMMAND_DATA,
           OFS_DRIVE_OUTPUT_CTRL, OFS_DRIVE_OUTPUT_CTRL, OFS_RATE_SELECT_MAIN};
    wv = '{8'h00, 8'h00, 8'h3c, 8'h15, 8'h01, 8'h80};
    for (int i = 0; i < 6; i++)
    begin
      if (i < 2)
        host_m.bus_read(wa[i], d);
      else
        host_m.bus_write(wa[i], wv[i]);
      check(fpd, 8'h00);
      check({rdstb, wrstb}, (i == 1) ? 8'h02 : (i == 2) ? 8'h01 : 8'h00);
      check(mot, (i == 3) ? 8'h01 : 8'h00);
      // motor or reset writes need restoring; timer start is then unknown
      if (i >= 3)
      begin
        host_m.bus_write(OFS_DRIVE_OUTPUT_CTRL, 8'h05);
        host_m.bus_write(OFS_RATE_SELECT_MAIN, 8'h03);
        await_sleep(0);
      end
      else
        await_sleep(N - 3);
    end
    $display("test wakes done");
  endtask

  // auto disable, direct powerdown, requests pass when awake
  task automatic test_direct();
    auto_cfg[CFG_FDC_BIT] = 1'b0;
    settle(2);
    check(fpd, 8'h00);
    fint = 1'b1;
    fdrq = 1'b1;
    fwd = 1'b1;
    fgate = 1'b1;
    settle(2);
    check({irq, drq}, 8'h03);
    check({wdo, wgo, mot_oe_n, dsel_oe_n, wr_oe_n}, 8'h18);
    fint = 1'b0;
    fdrq = 1'b0;
    fwd = 1'b0;
    fgate = 1'b0;
    direct_cfg[CFG_FDC_BIT] = 1'b1;
    settle(2);
    check(fpd, 8'h01);
    direct_cfg = 8'h00;
    settle(2);
    check(fpd, 8'h00);
    $display("test direct done");
  endtask

  //////////////////////////////////////////////////////////////
  // one serial port: enable, entry conditions, ring, wakes, direct
  task automatic test_uart(input int i);
    uart[i] = '{tx_hold_empty: 1'b1, tx_shift_empty: 1'b1, rx_fifo_empty: 1'b1,
                rx_idle: 1'b1, default: 1'b0};
    settle(2);
    check({txpd[i], rxpd[i]}, 8'h00);
    auto_cfg[CFG_UART1_BIT + i] = 1'b1;
    uart[i].tx_shift_empty = 1'b0;
    uart[i].rx_fifo_empty = 1'b0;
    settle(2);
    check({txpd[i], rxpd[i]}, 8'h00);
    uart[i].tx_shift_empty = 1'b1;
    uart[i].rx_fifo_empty = 1'b1;
    uart[i].rx_idle = 1'b0;
    settle(2);
    check({txpd[i], rxpd[i]}, 8'h02);
    uart[i].rx_idle = 1'b1;
    settle(2);
    check({txpd[i], rxpd[i]}, 8'h03);
    uart[i].ring_indication_in = 1'b1;
    @(negedge clk);
    check({ring[i], rxpd[i]}, 8'h03);
    @(negedge clk);
    check(ring[i], 8'h00);
    uart[i].serial_rx_input = 1'b1;
    @(negedge clk);
    check(rxpd[i], 8'h00);
    uart[i].tx_buf_write = 1'b1;
    @(negedge clk);
    uart[i].tx_buf_write = 1'b0;
    check(txpd[i], 8'h00);
    uart[i].tx_hold_empty = 1'b0;
    direct_cfg[CFG_UART1_BIT + i] = 1'b1;
    settle(2);
    check({txpd[i], rxpd[i]}, 8'h03);
    direct_cfg = 8'h00;
    auto_cfg[CFG_UART1_BIT + i] = 1'b0;
    settle(2);
    $display("test uart %0d done", i);
  endtask

  // parallel: every enable and auto config combination in modes 0, 1, 3 and 4
  task automatic test_parallel();
    logic [2:0] modes [4];
    logic e_exp, c_exp;
    modes = '{ECR_MODE_SPP, ECR_MODE_BIDIR, 3'h3, ECR_MODE_EPP};
    for (int k = 0; k < 32; k++)
    begin
      auto_cfg[CFG_PAR_BIT] = k[4];
      pepp = k[3];
      pecp = k[2];
      ecr = modes[k[1:0]];
      settle(2);
      e_exp = k[4] && (!pepp || (pecp && ecr != ECR_MODE_EPP));
      c_exp = k[4] && (!pecp || ecr != 3'h3);
      check({epd, cpd}, {6'h00, e_exp, c_exp});
    end
    $display("test parallel done");
  endtask

  //////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end

  // main sequence
  initial
  begin
    settle(10);
    rst_n = 1'b1;
    test_sleep();
    test_quiet();
    test_wakes();
    test_direct();
    test_uart(0);
    test_uart(1);
    test_parallel();
    test_done();
  end
endmodule // testbench
